// file: logic/rtm_map.svh
// Purpose: Offsets, request codes, options and mode values of the router command handler.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word.
// Notes: Definitions only; included by the design file and the testbench.
`ifndef RTM_MAP_SVH
`define RTM_MAP_SVH
// Register byte offsets.
`define RTM_OFF_CMD 8'h00
`define RTM_OFF_DLO 8'h04
`define RTM_OFF_DHI 8'h08
`define RTM_OFF_RESP 8'h0c
`define RTM_OFF_RLO 8'h10
`define RTM_OFF_RHI 8'h14
`define RTM_OFF_STAT 8'h18
`define RTM_OFF_CFG 8'h1c
// Request codes.
`define RTM_C_QSTAT 8'h51
`define RTM_C_PROXY 8'h52
`define RTM_C_CLRST 8'h53
`define RTM_C_XCVR 8'h54
`define RTM_C_QID 8'h61
`define RTM_C_RESPQ 8'h62
`define RTM_C_NODE 8'h6c
`define RTM_C_RMODE 8'h74
`define RTM_C_TCLR 8'h75
`define RTM_C_TDL 8'h76
`define RTM_C_GFWD 8'h77
`define RTM_C_SFWD 8'h78
`define RTM_C_GNF 8'h79
`define RTM_C_SNF 8'h7a
`define RTM_C_TRPT 8'h7b
`define RTM_C_RSTAT 8'h7c
`define RTM_C_ESC 8'h7d
// Response offsets: success and failure codes lie below the request code.
`define RTM_DIAG_OK 8'h20
`define RTM_DIAG_FAIL 8'h40
`define RTM_NM_OK 8'h40
`define RTM_NM_FAIL 8'h60
// Router-only error values reported by query status.
`define RTM_ERR_A 8'h9f
`define RTM_ERR_B 8'ha4
// Node-mode options and router-mode values.
`define RTM_TAKE_OFFLINE_OPTION 8'h01
`define RTM_BRING_ONLINE_OPTION 8'h02
`define RTM_MODE_NORMAL 2'h0
`define RTM_MODE_INIT 2'h1
`define RTM_MODE_BRIDGE 2'h2
`define RTM_ALG_CONFIGURED 2'h0
`define RTM_ALG_LEARNING 2'h1
// AXI responses.
`define RTM_OKAY 2'h0
`define RTM_SLVERR 2'h2
`endif

// file: logic/rtm_pkg.sv
// Purpose: Types of the router command handler.
// Assumes: Constants come from rtm_map.svh.
// Notes: Tables are indexed [side][domain][group=1/subnet=0][identifier].
`default_nettype none
package rtm_pkg;
    // Engine states, one-hot.
    typedef enum logic [2:0] {
        RTM_ST_INIT = 3'b001,
        RTM_ST_IDLE = 3'b010,
        RTM_ST_EXEC = 3'b100
    } rtm_st_t;
    // One forwarding table set: 2 sides x 2 domains x 2 kinds x 256 flags.
    typedef logic [1:0][1:0][1:0][255:0] rtm_tbl_t;
    // A request as software posts it.
    typedef struct packed {
        logic bcast;
        logic [7:0] arg2;
        logic [7:0] arg1;
        logic [7:0] code;
    } rtm_cmd_t;
    // Whole state of the handler.
    typedef struct packed {
        rtm_st_t st;
        rtm_cmd_t cmd;
        logic [63:0] data;
        logic [7:0] resp;
        logic done;
        logic silent;
        logic [63:0] rpt;
        logic [1:0] alg;
        logic [1:0] errsel;
        logic [1:0] mode;
        logic offline;
        logic esc;
        logic [7:0] csum;
        rtm_tbl_t pers;
        rtm_tbl_t work;
        logic aw_hold;
        logic [7:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic fwd_en;
        logic drop_foreign;
        logic bridge_all;
    } rtm_state_t;
endpackage : rtm_pkg
`default_nettype wire

// file: logic/rtm_cmd_handler.sv
// Purpose: Management command handler of a two-sided router with forwarding tables.
// Assumes: One 40 MHz clock, asynchronous active-high reset, AXI4-Lite register access.
// Notes: A request posted in CMD runs in one cycle; its answer shows in RESP.
// Operation
// R1: Answer standard diagnostic and identity requests.
// R2: Query status can report two router errors.
// R3: Offline and online apply to both sides.
// R4: Offline stops forwarding, drops foreign messages.
// R5: Broadcast node-mode requests are ignored.
// R6: Mode normal ends temporary bridge.
// R7: Mode init reloads or floods working tables.
// R8: Mode bridge forwards all until reset; here mode normal (0x00) also ends it.
// R9: Router mode affects both sides, answered.
// R10: Table clear zeroes one eight-byte segment.
// R11: Clear and download recompute stored checksum.
// R12: Download writes eight bytes into segment.
// R13: Bit zero is segment's lowest identifier.
// R14: Subnet zero is never forwarded.
// R15: Forward sets flag; persistent only if selected.
// R16: No-forward clears flag; persistent only if selected.
// R17: Single-flag checksum update only on persistent change.
// R18: Manager places domain and storage bits.
// R19: Escape prefix gives no response itself.
// R20: Escaped request acts on far side.
// R21: Router status returns algorithm and mode.
// R22: Table report returns eight table bytes.
// R23: Bad requests fail and change nothing; a node-mode request with another option answers success.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rtm_map.svh"
module rtm_cmd_handler
    import rtm_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic FWD_EN,
    output logic DROP_FOREIGN,
    output logic BRIDGE_ALL
);

    // Registered state and its next value.
    rtm_state_t q;
    rtm_state_t d;
    // Decoded request fields, valid while the engine executes.
    logic s;
    logic dom;
    logic grp;
    logic [1:0] seg;
    logic [7:0] ok_code;
    logic [7:0] fail_code;
    logic recalc;
    logic [32:0] rd_word;
    logic [31:0] wval;

    // Byte-lane merge of a write into a register's current contents.
    function automatic logic [31:0] rtm_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : rtm_merge

    // Register read mux; bit 32 flags an unmapped address.
    function automatic logic [32:0] rtm_read(input rtm_state_t st, input logic [7:0] a);
        logic [32:0] r;
        r = 33'h0;
        case (a)
            `RTM_OFF_CMD: r = {1'b0, 7'h0, st.cmd};
            `RTM_OFF_DLO: r = {1'b0, st.data[31:0]};
            `RTM_OFF_DHI: r = {1'b0, st.data[63:32]};
            `RTM_OFF_RESP: r = {1'b0, 22'h0, st.silent, st.done, st.resp};
            `RTM_OFF_RLO: r = {1'b0, st.rpt[31:0]};
            `RTM_OFF_RHI: r = {1'b0, st.rpt[63:32]};
            `RTM_OFF_STAT: r = {1'b0, 16'h0, st.csum, 3'h0, st.offline, st.mode, st.alg};
            `RTM_OFF_CFG: r = {1'b0, 28'h0, st.errsel, st.alg};
            default: r = {1'b1, 32'h0};
        endcase
        return r;
    endfunction : rtm_read

    // Checksum over the persistent tables; a byte-wise XOR is cheap and catches
    // any single corrupted flag, at the cost of missing two flips in the same bit of two bytes.
    function automatic logic [7:0] rtm_fold(input rtm_tbl_t t);
        logic [2047:0] f;
        logic [7:0] a;
        f = t;
        a = 8'h00;
        for (int k = 0; k < 256; k++)
        begin
            a = a ^ f[k*8 +: 8];
        end
        return a;
    endfunction : rtm_fold

    // Working tables after the init action: a copy of the persistent set when
    // configured, all flags set (flood) when learning.
    function automatic rtm_tbl_t rtm_init(input rtm_state_t st);
        rtm_tbl_t t;
        t = st.pers;
        if (st.alg == `RTM_ALG_LEARNING)
        begin
            t = '1;
        end
        return t;
    endfunction : rtm_init

    // Next-state logic: bus slave, command engine and forwarding controls.
    always_comb
    begin
        d = q;
        recalc = 1'b0;
        s = q.esc; // R20
        dom = q.cmd.arg1[1];
        grp = q.cmd.arg1[0];
        seg = q.cmd.arg1[7:6];
        // Diagnostic codes answer 0x20 lower, management codes 0x40 lower.
        if (q.cmd.code[7:4] == 4'h5)
        begin
            ok_code = q.cmd.code - `RTM_DIAG_OK;
            fail_code = q.cmd.code - `RTM_DIAG_FAIL;
        end
        else
        begin
            ok_code = q.cmd.code - `RTM_NM_OK;
            fail_code = q.cmd.code - `RTM_NM_FAIL;
        end
        rd_word = rtm_read(q, q.awaddr);
        wval = rtm_merge(rd_word[31:0], q.wdata, q.wstrb);

        // Write address and data are latched independently, in either order.
        if (q.awready && AWVALID)
        begin
            d.aw_hold = 1'b1;
            d.awaddr = AWADDR;
        end
        if (q.wready && WVALID)
        begin
            d.w_hold = 1'b1;
            d.wdata = WDATA;
            d.wstrb = WSTRB;
        end
        if (q.bvalid && BREADY)
        begin
            d.bvalid = 1'b0;
        end
        // Commit once both halves are held and the previous response is gone.
        if (q.aw_hold && q.w_hold && !q.bvalid)
        begin
            d.aw_hold = 1'b0;
            d.w_hold = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RTM_OKAY;
            case (q.awaddr)
                `RTM_OFF_CMD:
                begin
                    // A request posted while one runs is dropped; software polls done.
                    if (q.st == RTM_ST_IDLE)
                    begin
                        d.cmd = rtm_cmd_t'(wval[24:0]);
                        d.st = RTM_ST_EXEC;
                        d.done = 1'b0;
                        d.silent = 1'b0;
                    end
                end
                `RTM_OFF_DLO: d.data[31:0] = wval;
                `RTM_OFF_DHI: d.data[63:32] = wval;
                `RTM_OFF_CFG:
                begin
                    d.alg = wval[1:0];
                    d.errsel = wval[3:2];
                end
                `RTM_OFF_RESP, `RTM_OFF_RLO, `RTM_OFF_RHI, `RTM_OFF_STAT: ;
                default: d.bresp = `RTM_SLVERR;
            endcase
        end
        d.awready = !d.aw_hold;
        d.wready = !d.w_hold;

        // Read channel: one outstanding read, answered the cycle after the address.
        if (q.rvalid && RREADY)
        begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
        if (q.arready && ARVALID)
        begin
            rd_word = rtm_read(q, ARADDR);
            d.rdata = rd_word[31:0];
            d.rresp = rd_word[32] ? `RTM_SLVERR : `RTM_OKAY;
            d.rvalid = 1'b1;
            d.arready = 1'b0;
        end

        // Command engine.
        case (q.st)
            RTM_ST_INIT:
            begin
                // Reset performs the table init once the reset is released.
                d.work = rtm_init(q); // R7
                d.st = RTM_ST_IDLE;
            end
            RTM_ST_IDLE: ;
            RTM_ST_EXEC:
            begin
                d.st = RTM_ST_IDLE;
                d.done = 1'b1;
                d.resp = ok_code;
                d.esc = 1'b0;
                case (q.cmd.code)
                    `RTM_C_QSTAT:
                    begin
                        // Error byte carries a router-only code when selected.
                        case (q.errsel)
                            2'h1: d.rpt = {56'h0, `RTM_ERR_A}; // R2
                            2'h2: d.rpt = {56'h0, `RTM_ERR_B}; // R2
                            default: d.rpt = 64'h0; // R1
                        endcase
                    end
                    `RTM_C_PROXY, `RTM_C_CLRST, `RTM_C_XCVR, `RTM_C_QID, `RTM_C_RESPQ: ; // R1
                    `RTM_C_NODE:
                    begin
                        if (q.cmd.bcast)
                        begin
                            // Left for the forwarding path; no answer, no effect.
                            d.silent = 1'b1; // R5
                            d.resp = 8'h00;
                        end
                        else if (q.cmd.arg1 == `RTM_TAKE_OFFLINE_OPTION)
                        begin
                            d.offline = 1'b1; // R3
                        end
                        else if (q.cmd.arg1 == `RTM_BRING_ONLINE_OPTION)
                        begin
                            d.offline = 1'b0; // R3
                        end
                    end
                    `RTM_C_RMODE:
                    begin
                        // Mode state is shared, so it acts on both sides.
                        case (q.cmd.arg1) // R9
                            8'h00: d.mode = `RTM_MODE_NORMAL; // R6
                            8'h01: d.work = rtm_init(q); // R7
                            8'h02: d.mode = `RTM_MODE_BRIDGE; // R8
                            default: d.resp = fail_code; // R23
                        endcase
                    end
                    `RTM_C_TCLR:
                    begin
                        d.pers[s][dom][grp][{seg, 6'h00} +: 64] = 64'h0; // R10
                        d.work[s][dom][grp][{seg, 6'h00} +: 64] = 64'h0; // R10
                        recalc = 1'b1; // R11
                    end
                    `RTM_C_TDL:
                    begin
                        // Byte k bit b lands on identifier seg*64 + 8k + b.
                        d.pers[s][dom][grp][{seg, 6'h00} +: 64] = q.data; // R12 R13
                        recalc = 1'b1; // R11
                    end
                    `RTM_C_GFWD, `RTM_C_SFWD:
                    begin
                        d.work[s][dom][q.cmd.code == `RTM_C_GFWD][q.cmd.arg2] = 1'b1; // R15
                        if (q.cmd.arg1[7])
                        begin
                            d.pers[s][dom][q.cmd.code == `RTM_C_GFWD][q.cmd.arg2] = 1'b1; // R15
                            recalc = 1'b1; // R17
                        end
                    end
                    `RTM_C_GNF, `RTM_C_SNF:
                    begin
                        d.work[s][dom][q.cmd.code == `RTM_C_GNF][q.cmd.arg2] = 1'b0; // R16
                        if (q.cmd.arg1[7])
                        begin
                            d.pers[s][dom][q.cmd.code == `RTM_C_GNF][q.cmd.arg2] = 1'b0; // R16
                            recalc = 1'b1; // R17
                        end
                    end
                    `RTM_C_TRPT:
                    begin
                        if (q.cmd.arg1[2])
                        begin
                            d.rpt = q.pers[s][dom][grp][{seg, 6'h00} +: 64]; // R22
                        end
                        else
                        begin
                            d.rpt = q.work[s][dom][grp][{seg, 6'h00} +: 64]; // R22
                        end
                    end
                    `RTM_C_RSTAT: d.rpt = {60'h0, q.mode, q.alg}; // R21
                    `RTM_C_ESC:
                    begin
                        // The prefix arms the far side for the next request only.
                        d.esc = 1'b1; // R19
                        d.silent = 1'b1; // R19
                        d.resp = 8'h00;
                    end
                    default: d.resp = fail_code; // R23
                endcase
            end
            default: d.st = RTM_ST_IDLE;
        endcase

        // Subnet zero is reserved; its flag is held clear in every table.
        for (int i = 0; i < 4; i++)
        begin
            d.work[i / 2][i % 2][0][0] = 1'b0; // R14
            d.pers[i / 2][i % 2][0][0] = 1'b0; // R14
        end
        if (recalc)
        begin
            d.csum = rtm_fold(d.pers); // R11 R17
        end
        // Forwarding controls follow the state they are derived from.
        d.fwd_en = !d.offline; // R4
        d.drop_foreign = d.offline; // R4
        d.bridge_all = (d.mode == `RTM_MODE_BRIDGE); // R8
    end

    // State register; reset leaves the bridge off, online, tables empty.
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            q <= '0;
            q.st <= RTM_ST_INIT;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
            q.fwd_en <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // Every output is a flip-flop of the state.
    assign AWREADY = q.awready;
    assign WREADY = q.wready;
    assign BVALID = q.bvalid;
    assign BRESP = q.bresp;
    assign ARREADY = q.arready;
    assign RVALID = q.rvalid;
    assign RDATA = q.rdata;
    assign RRESP = q.rresp;
    assign FWD_EN = q.fwd_en;
    assign DROP_FOREIGN = q.drop_foreign;
    assign BRIDGE_ALL = q.bridge_all;

    // Checks on the engine, one cycle after a request executes (two for AST_NORMAL); the subnet-zero check holds every cycle.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    logic ex;
    assign ex = (q.st == RTM_ST_EXEC);

    AST_QSTAT_OK: assert property (ex && q.cmd.code == `RTM_C_QSTAT |=> // R1
        q.done && q.resp == (`RTM_C_QSTAT - `RTM_DIAG_OK))
        else $error("query status not answered with success");
    AST_QSTAT_ERR: assert property (ex && q.cmd.code == `RTM_C_QSTAT && q.errsel == 2'h2 // R2
        |=> q.rpt[7:0] == `RTM_ERR_B)
        else $error("router error not reported");
    AST_OFFLINE: assert property (ex && q.cmd.code == `RTM_C_NODE && !q.cmd.bcast && // R4
        q.cmd.arg1 == `RTM_TAKE_OFFLINE_OPTION |=> DROP_FOREIGN && !FWD_EN)
        else $error("offline did not stop forwarding");
    AST_BCAST: assert property (ex && q.cmd.code == `RTM_C_NODE && q.cmd.bcast // R5
        |=> $stable(q.offline) && q.silent)
        else $error("broadcast node mode acted");
    AST_NORMAL: assert property (ex && q.cmd.code == `RTM_C_RMODE && q.cmd.arg1 == 8'h00 // R6
        |=> !BRIDGE_ALL ##1 !BRIDGE_ALL)
        else $error("normal mode left bridge on");
    AST_INIT: assert property (ex && q.cmd.code == `RTM_C_RMODE && q.cmd.arg1 == 8'h01 && // R7
        q.alg == `RTM_ALG_CONFIGURED |=> q.work == q.pers)
        else $error("init did not copy tables");
    AST_BRIDGE: assert property (ex && q.cmd.code == `RTM_C_RMODE && q.cmd.arg1 == 8'h02 // R8
        |=> BRIDGE_ALL && q.resp == (`RTM_C_RMODE - `RTM_NM_OK))
        else $error("bridge mode not entered");
    AST_CSUM: assert property (ex && (q.cmd.code == `RTM_C_TCLR || q.cmd.code == `RTM_C_TDL) // R11
        |=> q.csum == rtm_fold(q.pers))
        else $error("checksum not recomputed");
    AST_SUB0: assert property (!q.work[0][0][0][0] && !q.pers[1][1][0][0]) // R14
        else $error("subnet zero marked for forwarding");
    AST_CSUM_KEEP: assert property (ex && q.cmd.code == `RTM_C_GFWD && !q.cmd.arg1[7] // R17
        |=> $stable(q.csum) && $stable(q.pers))
        else $error("ram-only forward touched persistent state");
    AST_ESC: assert property (ex && q.cmd.code == `RTM_C_ESC |=> q.silent && q.esc) // R19
        else $error("escape produced a response");
    AST_BADMODE: assert property (ex && q.cmd.code == `RTM_C_RMODE && q.cmd.arg1 > 8'h02 // R23
        |=> $stable(q.work) && q.resp == (`RTM_C_RMODE - `RTM_NM_FAIL))
        else $error("bad router mode not refused");

    COV_DOWNLOAD: cover property (ex && q.cmd.code == `RTM_C_TDL);
    COV_ESC_THEN: cover property (ex && q.cmd.code == `RTM_C_ESC ##[1:20] ex && q.esc);
    COV_OFFLINE: cover property ($rose(DROP_FOREIGN));
    COV_BRIDGE: cover property ($rose(BRIDGE_ALL) ##[1:50] $fell(BRIDGE_ALL));

endmodule : rtm_cmd_handler
`default_nettype wire

// file: dv/rtm_mgr_model.sv
// Purpose: Management tool model that posts requests over AXI4-Lite.
// Assumes: One write and one read at most in flight, changes after a rising edge.
// Notes: Waits end only by the answer or by the bench timeout.
`timescale 1ns/1ps
`default_nettype none
module rtm_mgr_model
    import rtm_pkg::*;
(
    input wire logic clock,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // Idle bus at time zero so the handler never sees an unknown request.
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // Address and data go out together; each drops on its own handshake.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask : wr
    // Read data and response are taken at the edge that sees rvalid high.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : rd
endmodule : rtm_mgr_model
`default_nettype wire

// file: dv/rtm_cmd_handler_tb.sv
// Purpose: Self-checking bench of the router command handler.
// Assumes: Requests reach the handler only through the manager model.
// Notes: Expected answers are worked out here from the request codes.
`timescale 1ns/1ps
`default_nettype none
`include "rtm_map.svh"
module rtm_cmd_handler_tb
    import rtm_pkg::*;
;
    logic clock;
    logic reset;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, fwd_en, drop_foreign, bridge_all;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    rtm_cmd_handler dut (
        .CLOCK(clock), .RESET(reset), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .FWD_EN(fwd_en),
        .DROP_FOREIGN(drop_foreign), .BRIDGE_ALL(bridge_all)
    );
    rtm_mgr_model mgr (
        .clock, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready
    );
    // A 25 ns clock.
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // A hang counts as a mismatch; the whole run needs far fewer cycles.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // Done plus success code: the request code less 0x20 or 0x40.
    function automatic logic [31:0] ok(input logic [7:0] c);
        return {24'h1, c - (c < 8'h60 ? 8'h20 : 8'h40)};
    endfunction : ok
    // Post a request and poll until done; the poll is bounded.
    task automatic cmd(input logic [7:0] c, a1, a2, input logic bc, output logic [31:0] rsp);
        logic [1:0] r;
        mgr.wr(`RTM_OFF_CMD, {7'h00, bc, a2, a1, c}, r);
        rsp = 32'h0;
        for (int n = 0; n < 20 && rsp[8] !== 1'b1; n++)
            mgr.rd(`RTM_OFF_RESP, rsp, r);
    endtask : cmd
    task automatic cmd_chk(input logic [7:0] c, a1, a2, input logic bc, input logic [31:0] e);
        logic [31:0] v;
        cmd(c, a1, a2, bc, v);
        chk(v & 32'h3ff, e);
    endtask : cmd_chk
    task automatic rpt_chk(input logic [7:0] a1, input logic [31:0] lo,
                           input logic [7:0] c = `RTM_C_TRPT);
        logic [31:0] v;
        logic [1:0] r;
        cmd(c, a1, 8'h00, 1'b0, v);
        mgr.rd(`RTM_OFF_RLO, v, r);
        chk(v, lo);
    endtask : rpt_chk
    task automatic stat_chk(input logic [7:0] cs);
        logic [31:0] v;
        logic [1:0] r;
        mgr.rd(`RTM_OFF_STAT, v, r);
        chk({24'h0, v[15:8]}, {24'h0, cs});
    endtask : stat_chk
    task automatic dl(input logic [7:0] a1, input logic [31:0] lo, hi);
        logic [1:0] r;
        mgr.wr(`RTM_OFF_DLO, lo, r);
        mgr.wr(`RTM_OFF_DHI, hi, r);
        cmd_chk(`RTM_C_TDL, a1, 8'h00, 1'b0, ok(`RTM_C_TDL));
    endtask : dl
    task automatic t_std();
        logic [7:0] codes [6] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h61, 8'h62};
        foreach (codes[i])
            cmd_chk(codes[i], 8'h00, 8'h00, 1'b0, ok(codes[i]));
        cmd_chk(8'h70, 8'h00, 8'h00, 1'b0, 32'h110);
    endtask : t_std
    task automatic t_node();
        cmd_chk(`RTM_C_NODE, `RTM_TAKE_OFFLINE_OPTION, 8'h00, 1'b0, ok(`RTM_C_NODE));
        chk({30'h0, fwd_en, drop_foreign}, 32'h1);
        cmd_chk(`RTM_C_NODE, `RTM_BRING_ONLINE_OPTION, 8'h00, 1'b1, 32'h300);
        chk({30'h0, fwd_en, drop_foreign}, 32'h1);
        cmd_chk(`RTM_C_NODE, `RTM_BRING_ONLINE_OPTION, 8'h00, 1'b0, ok(`RTM_C_NODE));
        chk({30'h0, fwd_en, drop_foreign}, 32'h2);
    endtask : t_node
    task automatic t_mode();
        logic [31:0] v;
        logic [1:0] r;
        cmd_chk(`RTM_C_RMODE, 8'h02, 8'h00, 1'b0, ok(`RTM_C_RMODE));
        chk({31'h0, bridge_all}, 32'h1);
        cmd_chk(`RTM_C_RSTAT, 8'h00, 8'h00, 1'b0, ok(`RTM_C_RSTAT));
        mgr.rd(`RTM_OFF_RLO, v, r);
        chk(v, 32'h8);
        cmd_chk(`RTM_C_RMODE, 8'h00, 8'h00, 1'b0, ok(`RTM_C_RMODE));
        chk({31'h0, bridge_all}, 32'h0);
        cmd_chk(`RTM_C_RMODE, 8'h03, 8'h00, 1'b0, 32'h114);
        mgr.wr(8'h40, 32'h0, r);
        chk({30'h0, r}, 32'h2);
        mgr.rd(8'h40, v, r);
        chk({v[29:0], r}, 32'h2);
    endtask : t_mode
    task automatic t_tbl();
        dl(8'h41, 32'h04030201, 32'h08070605);
        stat_chk(8'h08);
        cmd_chk(`RTM_C_GFWD, 8'h80, 8'h45, 1'b0, ok(`RTM_C_GFWD));
        rpt_chk(8'h45, 32'h04030221);
        rpt_chk(8'h41, 32'h00000020);
        stat_chk(8'h28);
        cmd_chk(`RTM_C_GNF, 8'h00, 8'h45, 1'b0, ok(`RTM_C_GNF));
        rpt_chk(8'h41, 32'h0);
        rpt_chk(8'h45, 32'h04030221);
        stat_chk(8'h28);
        cmd_chk(`RTM_C_RMODE, 8'h01, 8'h00, 1'b0, ok(`RTM_C_RMODE));
        rpt_chk(8'h41, 32'h04030221);
        dl(8'h00, 32'h000000ff, 32'h0);
        rpt_chk(8'h04, 32'h000000fe);
        stat_chk(8'hd6);
        cmd_chk(`RTM_C_TCLR, 8'h41, 8'h00, 1'b0, ok(`RTM_C_TCLR));
        rpt_chk(8'h45, 32'h0);
        stat_chk(8'hfe);
    endtask : t_tbl
    task automatic t_esc();
        logic [1:0] r;
        cmd_chk(`RTM_C_ESC, 8'h00, 8'h00, 1'b0, 32'h300);
        cmd_chk(`RTM_C_GFWD, 8'h00, 8'h08, 1'b0, ok(`RTM_C_GFWD));
        rpt_chk(8'h01, 32'h0);
        cmd_chk(`RTM_C_ESC, 8'h00, 8'h00, 1'b0, 32'h300);
        rpt_chk(8'h01, 32'h100);
        mgr.wr(`RTM_OFF_CFG, 32'h9, r);
        rpt_chk(8'h00, 32'ha4, `RTM_C_QSTAT);
        cmd_chk(`RTM_C_RMODE, 8'h01, 8'h00, 1'b0, ok(`RTM_C_RMODE));
        rpt_chk(8'h00, 32'hfffffffe);
    endtask : t_esc
    // Reset for 20 cycles, then two edges so the table init is over.
    initial
    begin
        reset = 1'b1;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        t_std();
        t_node();
        t_mode();
        t_tbl();
        t_esc();
        end_sim();
    end
endmodule : rtm_cmd_handler_tb
`default_nettype wire
